/* File: src/fic_pkg.sv */
package fic_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_FREQ_MHZ = 200;
  localparam int unsigned PULSE_TIME_US = 2000;
  localparam int unsigned PERIOD_TIME_US = 4000;
  localparam int unsigned PULSE_CYCLES = PULSE_TIME_US * CLK_FREQ_MHZ;
  localparam int unsigned PERIOD_CYCLES = PERIOD_TIME_US * CLK_FREQ_MHZ;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h28;
  localparam logic [7:0] ADDR_MASK_SYSTEM = 8'h29;
  localparam logic [7:0] ADDR_LATCHED_SYSTEM = 8'h2c;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hff;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam logic [3:0] LATCHED_RESET = 4'h0;
  localparam logic [3:0] RESERVED_READ = 4'h0;
  localparam logic PIN_RESET = 1'b1;

  // event positions inside the upper nibble of the system bytes
  localparam int unsigned NUM_EVENTS = 4;
  localparam int unsigned EVT_CLOCK_ERROR = 3;
  localparam int unsigned EVT_PLL_LOCK = 2;
  localparam int unsigned EVT_OVER_TEMP = 1;
  localparam int unsigned EVT_OVER_CURRENT = 0;

  typedef enum logic [1:0] {
    EVT_LEVEL = 2'h0,
    EVT_UNUSED = 2'h1,
    EVT_REPEAT = 2'h2,
    EVT_SINGLE = 2'h3
  } fic_event_mode_type;

  typedef enum logic [1:0] {
    PD_NONE = 2'h0,
    PD_UNMASKED = 2'h1,
    PD_ALL = 2'h2,
    PD_RESERVED = 2'h3
  } fic_powerdown_type;

  typedef struct packed {
    logic irq_polarity;
    fic_event_mode_type event_mode;
    fic_powerdown_type fault_powerdown_select;
    logic latched_readback_filter;
    logic fault_recovery_select;
    logic clear_latched_on_read_mode;
  } fic_config_type;

  typedef struct packed {
    logic [NUM_EVENTS-1:0] events;
    logic [3:0] reserved;
  } fic_system_byte_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } fic_reg_req_type;

endpackage : fic_pkg

/* File: src/fic_pulse_gen.sv */
`timescale 1ns/100ps
`default_nettype none

module fic_pulse_gen import fic_pkg::*; #(
  parameter int unsigned PULSE_LEN = PULSE_CYCLES,
  parameter int unsigned PERIOD_LEN = PERIOD_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire fic_event_mode_type mode,
  input wire logic active,
  input wire logic trigger,
  output logic pulse_out
);

  localparam int unsigned CW = $clog2(PERIOD_LEN + 1);
  localparam logic [CW-1:0] PULSE_LAST = CW'(PULSE_LEN - 1);
  localparam logic [CW-1:0] PERIOD_LAST = CW'(PERIOD_LEN - 1);
  localparam logic [CW-1:0] CNT_ZERO = '0;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_ON = 3'b010,
    S_OFF = 3'b100
  } fic_pulse_state_type;

  fic_pulse_state_type state, next_state;
  logic [CW-1:0] count, next_count;
  wire repeat_mode = (mode == EVT_REPEAT);
  wire single_mode = (mode == EVT_SINGLE);
  wire pulse_done = (count == PULSE_LAST);
  wire period_done = (count == PERIOD_LAST);
  wire [CW-1:0] count_inc = count + CW'(1);

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_count = count_inc;
    unique case (state)
      S_IDLE: begin
        next_count = CNT_ZERO;
        if ((repeat_mode && active) || (single_mode && trigger)) begin
          next_state = S_ON;
        end
      end
      S_ON: begin
        if (single_mode && trigger) begin
          next_count = CNT_ZERO;
        end else if (pulse_done) begin
          next_state = single_mode ? S_IDLE : S_OFF;
        end
      end
      S_OFF: begin
        // a switch to single mode mid-period drops the repeat gap
        if (single_mode) begin
          next_count = CNT_ZERO;
          next_state = trigger ? S_ON : S_IDLE;
        end else if (period_done) begin
          next_count = CNT_ZERO;
          next_state = S_ON;
        end
      end
      default: begin
        next_state = S_IDLE;
        next_count = CNT_ZERO;
      end
    endcase
    if (!repeat_mode && !single_mode) begin
      next_state = S_IDLE;
      next_count = CNT_ZERO;
    end else if (repeat_mode && !active) begin
      next_state = S_IDLE;
      next_count = CNT_ZERO;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= S_IDLE;
      count <= CNT_ZERO;
      pulse_out <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      pulse_out <= (next_state == S_ON);
    end
  end

  a_single_start: assert property (@(posedge clk) disable iff (reset) // RL4
    single_mode && trigger |=> pulse_out)
    else $error("single pulse did not start on event");

  a_repeat_cycle: assert property (@(posedge clk) disable iff (reset) // RL3
    state == S_OFF && period_done && repeat_mode && active
    |=> pulse_out)
    else $error("repeating pulse did not restart after period");

endmodule : fic_pulse_gen

`default_nettype wire

/* File: src/fic_controller.sv */
`timescale 1ns/100ps
`default_nettype none

// What this block does
// RL1: interrupt pin is active low with polarity 0, active high with 1.
// RL2: event mode 0 holds interrupt while unmasked latched event exists; 1 unused.
// RL3: event mode 2 pulses interrupt 2 ms per 4 ms while events pending.
// RL4: event mode 3 gives one 2 ms pulse per unmasked event.
// RL5: power-down code 0 never powers down channels or the bias.
// RL6: power-down code 1 powers down channels with unmasked faults only.
// RL7: power-down code 2 powers down channels on any fault; 3 reserved.
// RL8: bias fault under code 1 or 2 shuts bias and channels per setting.
// RL9: readback filter 0 shows all latched events, 1 only unmasked.
// RL10: recovery 0 powers channels back up once the fault is gone.
// RL11: recovery 1 leaves power-up to host via channel power-up register.
// RL12: clear mode 0: read clears a latched bit only if live is low.
// RL13: clear mode 1: read clears always; set again on new live rise.
// RL14: mask bit 7 masks clock error; resets masked.
// RL15: mask bit 6 masks pll lock; resets masked.
// RL16: mask bit 5 masks over-temperature; resets masked.
// RL17: mask bit 4 masks over-current; resets masked.
// RL18: host writes mask low nibble with ones only.
// RL19: latched bit 7 records clock error, bit 6 pll lock.
// RL20: latched bit sets on live rise and holds until cleared.
// RL21: event mode 0 releases interrupt when no unmasked event remains.
module fic_controller import fic_pkg::*; #(
  parameter int unsigned NUM_CHANNELS = 4,
  parameter int unsigned PULSE_LEN = PULSE_CYCLES,
  parameter int unsigned PERIOD_LEN = PERIOD_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire fic_reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rdata_valid,
  input wire logic [NUM_EVENTS-1:0] live_events,
  input wire logic [NUM_CHANNELS-1:0] channel_fault,
  input wire logic [NUM_CHANNELS-1:0] channel_fault_mask,
  input wire logic bias_fault,
  input wire logic bias_fault_shutdown_setting,
  input wire logic [NUM_CHANNELS-1:0] channel_powerup_strobe,
  output logic [NUM_CHANNELS-1:0] adc_channel_powerdown,
  output logic bias_powerdown,
  output logic interrupt_pin
);

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if (NUM_CHANNELS < 1 || NUM_CHANNELS > 8) begin : g_bad_channels
    $error("NUM_CHANNELS must be 1 to 8");
  end
  if (PULSE_LEN < 1 || PERIOD_LEN <= PULSE_LEN) begin : g_bad_timing
    $error("need 1 <= PULSE_LEN < PERIOD_LEN");
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  localparam logic [NUM_CHANNELS-1:0] CH_NONE = '0;
  localparam logic [NUM_CHANNELS-1:0] CH_ALL = '1;
  localparam logic [NUM_EVENTS-1:0] EV_ALL = '1;

  function automatic logic [7:0] fic_pack_system(
    input logic [NUM_EVENTS-1:0] ev
  );
    fic_system_byte_type b;
    b.events = ev;
    b.reserved = RESERVED_READ;
    return b;
  endfunction : fic_pack_system

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  fic_config_type interrupt_config;
  fic_system_byte_type interrupt_mask_system;
  logic [NUM_EVENTS-1:0] latched_events, live_prev;
  logic [NUM_CHANNELS-1:0] next_powerdown;
  logic [7:0] next_rdata;
  logic next_asserted, next_pin, pulse_out;

  wire write_config = reg_req.write && reg_req.addr == ADDR_CONFIG;
  wire write_mask = reg_req.write && reg_req.addr == ADDR_MASK_SYSTEM;
  wire read_latched = reg_req.read && reg_req.addr == ADDR_LATCHED_SYSTEM;

  // reserved mask bits are plain storage; the host keeps them at one
  always_ff @(posedge clk) begin
    if (reset) begin
      interrupt_config <= CONFIG_RESET;
      interrupt_mask_system <= MASK_RESET; // RL14 RL15 RL16 RL17 RL18
    end else begin
      if (write_config) begin
        interrupt_config <= reg_req.wdata;
      end
      if (write_mask) begin
        interrupt_mask_system <= reg_req.wdata;
      end
    end
  end

  wire [NUM_EVENTS-1:0] system_event_masks = interrupt_mask_system.events;
  wire irq_polarity = interrupt_config.irq_polarity;
  wire fic_event_mode_type event_mode = interrupt_config.event_mode;
  wire fic_powerdown_type fault_powerdown_select =
    interrupt_config.fault_powerdown_select;
  wire latched_readback_filter = interrupt_config.latched_readback_filter;
  wire fault_recovery_select = interrupt_config.fault_recovery_select;
  wire clear_latched_on_read_mode =
    interrupt_config.clear_latched_on_read_mode;

  // ---------------------------------------------------------------
  // latched status
  // ---------------------------------------------------------------
  wire [NUM_EVENTS-1:0] live_rise = live_events & ~live_prev; // RL20
  wire [NUM_EVENTS-1:0] unmasked_latched =
    latched_events & ~system_event_masks;
  wire [NUM_EVENTS-1:0] visible_latched =
    latched_readback_filter ? unmasked_latched : latched_events; // RL9
  wire [NUM_EVENTS-1:0] clear_allowed =
    clear_latched_on_read_mode ? EV_ALL : ~live_events; // RL12 RL13
  wire [NUM_EVENTS-1:0] clear_bits =
    read_latched ? (visible_latched & clear_allowed) : '0;
  // a rise in the clearing cycle wins over the clear
  wire [NUM_EVENTS-1:0] next_latched =
    (latched_events & ~clear_bits) | live_rise; // RL19 RL20
  wire any_unmasked = |unmasked_latched;
  wire new_unmasked_event = |(live_rise & ~system_event_masks);

  always_ff @(posedge clk) begin
    if (reset) begin
      latched_events <= LATCHED_RESET;
      live_prev <= LATCHED_RESET;
    end else begin
      latched_events <= next_latched;
      live_prev <= live_events;
    end
  end

  // ---------------------------------------------------------------
  // register readback
  // ---------------------------------------------------------------
  always_comb begin
    unique case (reg_req.addr)
      ADDR_CONFIG: next_rdata = interrupt_config;
      ADDR_MASK_SYSTEM: next_rdata = interrupt_mask_system;
      ADDR_LATCHED_SYSTEM: next_rdata = fic_pack_system(visible_latched);
      default: next_rdata = READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= READ_UNMAPPED;
      reg_rdata_valid <= 1'b0;
    end else begin
      reg_rdata_valid <= reg_req.read;
      if (reg_req.read) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt pin
  // ---------------------------------------------------------------
  fic_pulse_gen #(
    .PULSE_LEN(PULSE_LEN),
    .PERIOD_LEN(PERIOD_LEN)
  ) u_pulse_gen (
    .clk(clk),
    .reset(reset),
    .mode(event_mode),
    .active(any_unmasked), // RL3
    .trigger(new_unmasked_event), // RL4
    .pulse_out(pulse_out)
  );

  // the unused code behaves as the level mode
  wire level_mode = (event_mode == EVT_LEVEL) || (event_mode == EVT_UNUSED);

  always_comb begin
    next_asserted = level_mode ? any_unmasked : pulse_out; // RL2 RL21
    next_pin = irq_polarity ? next_asserted : ~next_asserted; // RL1
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      interrupt_pin <= PIN_RESET;
    end else begin
      interrupt_pin <= next_pin;
    end
  end

  // ---------------------------------------------------------------
  // fault power-down
  // ---------------------------------------------------------------
  wire pd_enabled = (fault_powerdown_select == PD_UNMASKED) ||
    (fault_powerdown_select == PD_ALL); // RL5
  wire [NUM_CHANNELS-1:0] channel_cause =
    (fault_powerdown_select == PD_ALL) ? channel_fault : // RL7
    (fault_powerdown_select == PD_UNMASKED) ?
      (channel_fault & ~channel_fault_mask) : CH_NONE; // RL6
  wire bias_cause = pd_enabled && bias_fault; // RL8
  wire [NUM_CHANNELS-1:0] all_cause =
    (bias_cause && bias_fault_shutdown_setting) ? CH_ALL : CH_NONE;
  wire [NUM_CHANNELS-1:0] pd_cause = channel_cause | all_cause;
  // manual recovery waits for the host's power-up strobe
  wire [NUM_CHANNELS-1:0] pd_release = ~pd_cause &
    (fault_recovery_select ? channel_powerup_strobe : CH_ALL); // RL10 RL11

  always_comb begin
    next_powerdown = pd_cause | (adc_channel_powerdown & ~pd_release);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      adc_channel_powerdown <= CH_NONE;
      bias_powerdown <= 1'b0;
    end else begin
      adc_channel_powerdown <= next_powerdown;
      bias_powerdown <= bias_cause; // RL8
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_read_latched;
    reg_req.read && reg_req.addr == ADDR_LATCHED_SYSTEM;
  endsequence

  sequence s_level_pending;
    level_mode && any_unmasked && !write_config;
  endsequence

  sequence s_level_idle;
    level_mode && !any_unmasked && !write_config;
  endsequence

  // trigger, then a quiet cycle in which the pulse generator answers
  sequence s_single_trigger;
    event_mode == EVT_SINGLE && new_unmasked_event && !write_config
    ##1 !write_config;
  endsequence

  a_pin_level_hold: assert property ( // RL2 RL1
    s_level_pending |=> interrupt_pin == irq_polarity)
    else $error("level interrupt not asserted");

  a_pin_level_release: assert property ( // RL21 RL1
    s_level_idle |=> interrupt_pin == !irq_polarity)
    else $error("level interrupt not released");

  a_single_pin_start: assert property ( // RL4 RL1
    s_single_trigger |=> interrupt_pin == irq_polarity)
    else $error("single pulse did not reach the pin");

  a_mask_reset_value: assert property ( // RL14 RL15 RL16 RL17
    @(posedge clk) disable iff (1'b0)
    reset |=> interrupt_mask_system == MASK_RESET)
    else $error("system masks not reset to masked");

  a_config_reset_value: assert property ( // RL1
    @(posedge clk) disable iff (1'b0)
    reset |=> interrupt_config == CONFIG_RESET && interrupt_pin == PIN_RESET)
    else $error("config or pin not at reset value");

  a_mask_write: assert property ( // RL14 RL15 RL16 RL17
    write_mask |=> interrupt_mask_system == $past(reg_req.wdata))
    else $error("mask write not taken");

  a_latch_set_rise: assert property ( // RL20 RL19
    |live_rise |=> (latched_events & $past(live_rise)) == $past(live_rise))
    else $error("latched bit missed a live rise");

  a_latch_hold: assert property ( // RL20
    !read_latched && live_rise == '0
    |=> latched_events == $past(latched_events))
    else $error("latched bit changed without cause");

  a_latch_set_only_rise: assert property ( // RL13 RL20
    live_rise == '0 |=> (latched_events & ~$past(latched_events)) == '0)
    else $error("latched bit set without a live rise");

  a_latch_keep_live: assert property ( // RL12
    s_read_latched ##0 !clear_latched_on_read_mode
    |=> (latched_events & $past(latched_events & live_events))
      == $past(latched_events & live_events))
    else $error("latched bit cleared while live high");

  a_latch_clear_any: assert property ( // RL13
    s_read_latched ##0 clear_latched_on_read_mode ##0 live_rise == '0
    |=> (latched_events & $past(visible_latched)) == '0)
    else $error("read did not clear visible bits");

  a_latch_masked_keep: assert property ( // RL9
    s_read_latched ##0 latched_readback_filter
    |=> (latched_events & $past(latched_events & system_event_masks))
      == $past(latched_events & system_event_masks))
    else $error("hidden latched bit cleared by read");

  a_readback_filter: assert property ( // RL9
    reg_req.read && reg_req.addr == ADDR_LATCHED_SYSTEM &&
      latched_readback_filter && !write_mask
    |=> (reg_rdata[7:4] & system_event_masks) == '0)
    else $error("masked event visible in readback");

  a_readback_all: assert property ( // RL9 RL19
    s_read_latched ##0 !latched_readback_filter
    |=> reg_rdata == fic_pack_system($past(latched_events)))
    else $error("latched readback does not show all events");

  a_pd_code_none: assert property ( // RL5
    fault_powerdown_select == PD_NONE && !write_config
    |=> (adc_channel_powerdown & ~$past(adc_channel_powerdown)) == '0
      && !bias_powerdown)
    else $error("power-down taken with faults unused");

  a_pd_unmasked: assert property ( // RL6
    fault_powerdown_select == PD_UNMASKED
    |=> ($past(channel_fault & ~channel_fault_mask) &
      ~adc_channel_powerdown) == '0)
    else $error("unmasked fault did not power down");

  a_pd_any_fault: assert property ( // RL7
    fault_powerdown_select == PD_ALL
    |=> ($past(channel_fault) & ~adc_channel_powerdown) == '0)
    else $error("fault did not power down channel");

  a_bias_shutdown: assert property ( // RL8
    pd_enabled && bias_fault && bias_fault_shutdown_setting
    |=> bias_powerdown && adc_channel_powerdown == CH_ALL)
    else $error("bias fault shutdown missing");

  a_bias_release: assert property ( // RL8 RL5
    !(pd_enabled && bias_fault) |=> !bias_powerdown)
    else $error("bias powered down without a bias fault");

  a_auto_recover: assert property ( // RL10
    !fault_recovery_select && pd_cause == '0
    |=> adc_channel_powerdown == '0)
    else $error("channel not recovered automatically");

  a_manual_hold: assert property ( // RL11
    fault_recovery_select && channel_powerup_strobe == '0 && !write_config
    |=> (adc_channel_powerdown & $past(adc_channel_powerdown))
      == $past(adc_channel_powerdown))
    else $error("channel recovered without host power-up");

endmodule : fic_controller

`default_nettype wire

/* File: test/fic_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

module fic_host_model import fic_pkg::*; #(
  parameter int unsigned NC = 4
) (
  input wire logic clk,
  output var fic_reg_req_type reg_req,
  output logic [NC-1:0] channel_powerup_strobe
);

  initial begin
    reg_req <= '0;
    channel_powerup_strobe <= '0;
  end

  // ---------------------------------------------------------------
  // register access
  // ---------------------------------------------------------------
  // released address and data lines show the inverse, never stale values
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.write <= 1'b1;
    @(posedge clk);
    reg_req.write <= 1'b0;
    reg_req.addr <= ~a;
    reg_req.wdata <= ~d;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a);
    @(posedge clk);
    reg_req.addr <= a;
    reg_req.read <= 1'b1;
    @(posedge clk);
    reg_req.read <= 1'b0;
    reg_req.addr <= ~a;
    @(posedge clk);
  endtask : read_reg

  // unused event mode and reserved power-down code are never written
  task automatic write_config(input fic_config_type c);
    if (c.event_mode != EVT_UNUSED &&
        c.fault_powerdown_select != PD_RESERVED) begin
      write_reg(ADDR_CONFIG, c);
    end
  endtask : write_config

  task automatic write_mask(input logic [3:0] ev);
    write_reg(ADDR_MASK_SYSTEM, {ev, 4'hf});
  endtask : write_mask

  // ---------------------------------------------------------------
  // manual channel power-up
  // ---------------------------------------------------------------
  task automatic power_up(input logic [NC-1:0] ch);
    @(posedge clk);
    channel_powerup_strobe <= ch;
    @(posedge clk);
    channel_powerup_strobe <= '0;
  endtask : power_up

endmodule : fic_host_model

`default_nettype wire

/* File: test/fault_interrupt_config_tb.sv */
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module fault_interrupt_config_tb import fic_pkg::*;;

  localparam int PL = 4;
  localparam int PP = 10;
  localparam int NCH = 4;
  localparam logic [7:0] LAT = ADDR_LATCHED_SYSTEM;

  logic clk;
  logic reset;
  fic_reg_req_type reg_req;
  logic [7:0] reg_rdata;
  logic reg_rdata_valid;
  logic [3:0] live_events;
  logic [3:0] channel_fault;
  logic [3:0] channel_fault_mask;
  logic bias_fault;
  logic bias_fault_shutdown_setting;
  logic [3:0] channel_powerup_strobe;
  logic [3:0] adc_channel_powerdown;
  logic bias_powerdown;
  logic interrupt_pin;
  int fail_count = 0;
  int checks = 0;
  logic [7:0] exp_q[$];

  fic_controller #(
    .NUM_CHANNELS(NCH),
    .PULSE_LEN(PL),
    .PERIOD_LEN(PP)
  ) u_dut (
    .clk(clk),
    .reset(reset),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid),
    .live_events(live_events),
    .channel_fault(channel_fault),
    .channel_fault_mask(channel_fault_mask),
    .bias_fault(bias_fault),
    .bias_fault_shutdown_setting(bias_fault_shutdown_setting),
    .channel_powerup_strobe(channel_powerup_strobe),
    .adc_channel_powerdown(adc_channel_powerdown),
    .bias_powerdown(bias_powerdown),
    .interrupt_pin(interrupt_pin)
  );

  fic_host_model #(
    .NC(NCH)
  ) u_host (
    .clk(clk),
    .reg_req(reg_req),
    .channel_powerup_strobe(channel_powerup_strobe)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // read data scoreboard
  // ---------------------------------------------------------------
  always @(posedge clk) begin : mon
    logic [7:0] e;
    if (reg_rdata_valid === 1'b1) begin
      if (exp_q.size() == 0) `CHK(reg_rdata_valid, 1'b0)
      else begin
        e = exp_q.pop_front();
        `CHK(reg_rdata, e)
      end
    end
  end

  task automatic give_verdict();
    if (fail_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.read_reg(a);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // counts asserted (low) pin cycles from the first one seen
  task automatic count_low(input int n, input int e);
    int i;
    int c;
    c = 0;
    for (i = 0; i < 40 && interrupt_pin !== 1'b0; i++) @(negedge clk);
    if (i == 40) begin
      fail_count++;
      give_verdict();
    end else begin
      repeat (n) begin
        if (interrupt_pin === 1'b0) c++;
        @(negedge clk);
      end
      `CHK(c, e)
    end
  endtask : count_low

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [3:0] f, m, pd;
    logic s;
    reset <= 1'b1;
    live_events <= '0;
    channel_fault <= '0;
    channel_fault_mask <= '0;
    bias_fault <= 1'b0;
    bias_fault_shutdown_setting <= 1'b0;
    void'($urandom(32'hbafd));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd(ADDR_CONFIG, 8'h00);
    rd(ADDR_MASK_SYSTEM, 8'hff);
    rd(LAT, 8'h00);
    rd(8'h2a, READ_UNMAPPED);
    u_host.write_reg(8'h2a, 8'hff);
    rd(ADDR_CONFIG, 8'h00);
    `CHK(interrupt_pin, PIN_RESET)
    // latch, hold while live, clear once live is gone
    @(posedge clk) live_events <= 4'hf;
    cyc(4);
    `CHK(interrupt_pin, 1'b1)
    rd(LAT, 8'hf0);
    rd(LAT, 8'hf0);
    @(posedge clk) live_events <= 4'h0;
    rd(LAT, 8'hf0);
    rd(LAT, 8'h00);
    for (int i = 0; i < 4; i++) begin
      u_host.write_mask(~(4'h1 << i));
      @(posedge clk) live_events <= ~(4'h1 << i);
      cyc(4);
      `CHK(interrupt_pin, 1'b1)
      @(posedge clk) live_events <= 4'hf;
      cyc(4);
      `CHK(interrupt_pin, 1'b0)
      @(posedge clk) live_events <= 4'h0;
      rd(LAT, 8'hf0);
      cyc(3);
      `CHK(interrupt_pin, 1'b1)
    end
    u_host.write_mask(4'h7);
    u_host.write_config(8'h80);
    cyc(2);
    `CHK(interrupt_pin, 1'b0)
    @(posedge clk) live_events <= 4'h8;
    cyc(4);
    `CHK(interrupt_pin, 1'b1)
    @(posedge clk) live_events <= 4'h0;
    rd(LAT, 8'h80);
    cyc(3);
    `CHK(interrupt_pin, 1'b0)
    u_host.write_config(8'h04);
    @(posedge clk) live_events <= 4'hc;
    cyc(4);
    rd(LAT, 8'h80);
    u_host.write_config(8'h00);
    rd(LAT, 8'hc0);
    u_host.write_config(8'h01);
    rd(LAT, 8'hc0);
    rd(LAT, 8'h00);
    @(posedge clk) live_events <= 4'h0;
    cyc(2);
    @(posedge clk) live_events <= 4'h8;
    cyc(3);
    rd(LAT, 8'h80);
    @(posedge clk) live_events <= 4'h0;
    // pulse modes
    u_host.write_config(8'h40);
    @(posedge clk) live_events <= 4'h8;
    count_low(2 * PP, 2 * PL);
    @(posedge clk) live_events <= 4'h0;
    rd(LAT, 8'h80);
    cyc(3);
    `CHK(interrupt_pin, 1'b1)
    u_host.write_config(8'h60);
    @(posedge clk) live_events <= 4'h8;
    count_low(2 * PP, PL);
    @(posedge clk) live_events <= 4'h0;
    rd(LAT, 8'h80);
    // fault power-down codes
    for (int c = 0; c < 3; c++) begin
      f = 4'($urandom);
      m = 4'($urandom);
      s = 1'($urandom);
      @(posedge clk) begin
        channel_fault <= f;
        channel_fault_mask <= m;
      end
      u_host.write_config({3'h0, 2'(c), 3'h0});
      pd = (c == 0) ? 4'h0 : (c == 1) ? (f & ~m) : f;
      cyc(3);
      `CHK(adc_channel_powerdown, pd)
      @(posedge clk) begin
        bias_fault <= 1'b1;
        bias_fault_shutdown_setting <= s;
      end
      cyc(3);
      `CHK(bias_powerdown, c != 0)
      `CHK(adc_channel_powerdown, (c != 0 && s) ? 4'hf : pd)
      @(posedge clk) begin
        bias_fault <= 1'b0;
        channel_fault <= 4'h0;
      end
      cyc(3);
      `CHK(adc_channel_powerdown, 4'h0)
    end
    u_host.write_config(8'h12);
    @(posedge clk) channel_fault <= 4'h5;
    cyc(3);
    `CHK(adc_channel_powerdown, 4'h5)
    @(posedge clk) channel_fault <= 4'h0;
    cyc(3);
    `CHK(adc_channel_powerdown, 4'h5)
    u_host.power_up(4'h1);
    cyc(2);
    `CHK(adc_channel_powerdown, 4'h4)
    u_host.power_up(4'h4);
    cyc(2);
    `CHK(adc_channel_powerdown, 4'h0)
    cyc(2);
    `CHK(exp_q.size(), 0)
    give_verdict();
  end

endmodule : fault_interrupt_config_tb

`default_nettype wire
